// File: logic/brush_dc_hbridge_control.sv
// control logic of a full-bridge brushed dc motor driver
// assumes comparator and detector flags arrive asynchronously to mclk
//
// What this block does
// - both inputs low: all switches off
// - a high, b low: highA, lowB on
// - a low, b high: lowA, highB on
// - both high: both lows on, highs off
// - dead time before complementary switch on
// - fixed off-time for limit and overcurrent
// - blank limit compare after switch-on
// - limit reached: drive off 35 us
// - overcurrent: off 142 us
// - any undervoltage disables all outputs
// - fault output high when driving normally
// - fault output pulses 90 kHz in off-time
// - fault output low on undervoltage_lockout, ocp, thermal
// - low-pass filter on direction inputs
// - off-time drops high side, slow decay
// - overcurrent: all off, then resume
`default_nettype none

module brush_dc_hbridge_control
    import hbridge_pkg::*;
#(
    parameter int FILTER_CYC = FLT_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic dirInputA,
    input wire logic dirInputB,
    input wire flags_t senseFlags,
    output switches_t bridgeSwitches,
    output logic faultIndicator
);

    typedef struct packed {
        logic [2:0] syncA;
        logic [2:0] syncB;
        flags_t syncF1;
        flags_t syncF2;
        logic [1:0] dirFilt;
        logic [7:0] filtCnt;
        bridge_t applied;
        state_t state;
        logic [10:0] timer;
        logic [7:0] diagCnt;
        logic diagTog;
        switches_t sw;
        logic fault;
    } regs_t;

    regs_t r_q;
    regs_t r_d;

    // switch pattern of a bridge state; chop drops the high side
    function automatic switches_t decode(input bridge_t b, input logic chop);
        switches_t s;
        s = '0;
        case (b)
            BR_FWD: begin
                s.highA = ~chop;
                s.lowB = 1'b1;
            end
            BR_REV: begin
                s.lowA = 1'b1;
                s.highB = ~chop;
            end
            BR_BRAKE: begin
                s.lowA = 1'b1;
                s.lowB = 1'b1;
            end
            default: s = '0;
        endcase
        return s;
    endfunction : decode

    // timer load so that a timed state lasts exactly n cycles
    function automatic logic [10:0] span(input int n);
        return 11'(n - 1);
    endfunction : span

    // supply or thermal trouble stops the bridge outright
    function automatic logic halted(input flags_t f);
        return f.uvMain | f.uvLogic | f.uvPump | f.thermal;
    endfunction : halted

    logic haltAny;
    logic ocpHit;
    logic [1:0] dirRaw;
    logic [1:0] dirPrev;

    always_comb begin
        r_d = r_q;
        // two-flop synchronisers, a third stage only feeds the filter
        r_d.syncA = {r_q.syncA[1:0], dirInputA};
        r_d.syncB = {r_q.syncB[1:0], dirInputB};
        r_d.syncF1 = senseFlags;
        r_d.syncF2 = r_q.syncF1;
        dirRaw = {r_q.syncB[1], r_q.syncA[1]};
        dirPrev = {r_q.syncB[2], r_q.syncA[2]};
        haltAny = halted(r_q.syncF2);
        ocpHit = r_q.syncF2.overcurrent && r_q.state != ST_OCP && r_q.state != ST_OFF;

        // input must stay stable FILTER_CYC cycles to be accepted
        if (dirRaw == r_q.dirFilt) begin
            r_d.filtCnt = '0;
        end else if (dirRaw != dirPrev) begin
            // a fresh level restarts the count, so mixed noise never adds up
            r_d.filtCnt = 8'h01;
        end else if (r_q.filtCnt >= 8'(FILTER_CYC - 1)) begin
            r_d.filtCnt = '0;
            r_d.dirFilt = dirRaw;
        end else begin
            r_d.filtCnt = r_q.filtCnt + 8'h01;
        end

        // one shared down-counter times every timed state
        if (r_q.timer != '0) begin
            r_d.timer = r_q.timer - 11'h001;
        end

        case (r_q.state)
            ST_OFF: begin
                // waiting for a non-coast command
                if (bridge_t'(r_q.dirFilt) != BR_COAST) begin
                    r_d.applied = bridge_t'(r_q.dirFilt);
                    r_d.state = ST_DEAD;
                    r_d.timer = span(DEAD_CYC);
                end
            end
            ST_DEAD: begin
                // all switches off before any switch turns on
                if (r_q.timer == '0) begin
                    r_d.state = ST_ON;
                    r_d.timer = span(BLANK_CYC);
                end
            end
            ST_ON: begin
                // current limit only counts once the blank has run out
                if (bridge_t'(r_q.dirFilt) != r_q.applied) begin
                    r_d.state = ST_OFF;
                end else if (r_q.timer == '0 && r_q.syncF2.currentLimit) begin
                    r_d.state = ST_CHOP;
                    r_d.timer = span(OFF_CYC);
                end
            end
            ST_CHOP: begin
                // slow decay off-time, then dead time and drive again
                if (bridge_t'(r_q.dirFilt) != r_q.applied) begin
                    r_d.state = ST_OFF;
                end else if (r_q.timer == '0) begin
                    r_d.state = ST_DEAD;
                    r_d.timer = span(DEAD_CYC);
                end
            end
            ST_OCP: begin
                // all off for the overcurrent time, then restart from off
                if (r_q.timer == '0) begin
                    r_d.state = ST_OFF;
                end
            end
            default: r_d.state = ST_OFF;
        endcase

        // supply and thermal faults stop at once, with no timer
        if (haltAny) begin
            r_d.state = ST_OFF;
            r_d.timer = '0;
        end else if (ocpHit) begin
            // overcurrent aborts drive and a running limit off-time
            r_d.state = ST_OCP;
            r_d.timer = span(OCP_OFF_CYC);
        end

        case (r_d.state)
            ST_ON: r_d.sw = decode(r_d.applied, 1'b0);
            ST_CHOP: r_d.sw = decode(r_d.applied, 1'b1);
            ST_DEAD: r_d.sw = '0;
            ST_OCP: r_d.sw = '0;
            default: r_d.sw = '0;
        endcase

        // free-running diag oscillator, unrelated to drive timing
        if (r_q.diagCnt >= 8'(DIAG_HALF_CYC - 1)) begin
            r_d.diagCnt = '0;
            r_d.diagTog = ~r_q.diagTog;
        end else begin
            r_d.diagCnt = r_q.diagCnt + 8'h01;
        end

        // diag output: low on fault, pulses in off-time, else high
        if (haltAny || r_q.state == ST_OCP) begin
            r_d.fault = 1'b0;
        end else if (r_q.state == ST_CHOP) begin
            r_d.fault = r_q.diagTog;
        end else begin
            r_d.fault = 1'b1;
        end
    end

    // whole state in one register, cleared by reset
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs come straight from flops
    assign bridgeSwitches = r_q.sw;
    assign faultIndicator = r_q.fault;

endmodule : brush_dc_hbridge_control

`default_nettype wire

// File: logic/hbridge_pkg.sv
// package for the brushed dc h-bridge control logic
// assumes a single 10 MHz control clock
package hbridge_pkg;

    localparam int CLK_HZ = 10000000;
    localparam int DEAD_NS = 150;
    localparam int DEAD_MAX_NS = 750;
    localparam int BLANK_US = 5;
    localparam int OFF_US = 35;
    localparam int OCP_OFF_US = 142;
    localparam int OCP_ON_US = 5;
    localparam int FLT_NS = 2000;
    localparam int DIAG_KHZ = 90;

    // least times round up, longest round down
    localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int BLANK_CYC = BLANK_US * (CLK_HZ / 1000000);
    localparam int OFF_CYC = OFF_US * (CLK_HZ / 1000000);
    localparam int OCP_OFF_CYC = OCP_OFF_US * (CLK_HZ / 1000000);
    localparam int OCP_ON_CYC = OCP_ON_US * (CLK_HZ / 1000000);
    localparam int FLT_CYC = FLT_NS * (CLK_HZ / 1000000) / 1000;
    localparam int DIAG_HALF_CYC = CLK_HZ / (DIAG_KHZ * 1000 * 2);

    localparam logic [1:0] RESET_DIR = 2'h0;

    typedef enum logic [1:0] {
        BR_COAST = 2'h0,
        BR_FWD = 2'h1,
        BR_REV = 2'h2,
        BR_BRAKE = 2'h3
    } bridge_t;

    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_DEAD = 3'h1,
        ST_ON = 3'h3,
        ST_CHOP = 3'h2,
        ST_OCP = 3'h6
    } state_t;

    // four switches of the bridge
    typedef struct packed {
        logic highA;
        logic lowA;
        logic highB;
        logic lowB;
    } switches_t;

    // synchronised analog and supply flags
    typedef struct packed {
        logic currentLimit;
        logic overcurrent;
        logic thermal;
        logic uvMain;
        logic uvLogic;
        logic uvPump;
    } flags_t;

endpackage : hbridge_pkg

// File: sim/hb_checker.sv
// port checker for the h-bridge control
// assumes binding onto brush_dc_hbridge_control
`default_nettype none
module hb_checker
    import hbridge_pkg::*;
#(
    parameter int FILTER_CYC = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic dirInputA,
    input wire logic dirInputB,
    input wire flags_t senseFlags,
    input wire switches_t bridgeSwitches,
    input wire logic faultIndicator
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire switches_t sw = bridgeSwitches;
    a_no_shoot: assert property (!(sw.highA && sw.lowA) && !(sw.highB && sw.lowB))
        else $error("shoot-through");
    a_dead_gap: assert property ($rose(|sw) |-> $past(sw) == 4'h0 && $past(sw, 2) == 4'h0)
        else $error("no dead time");
    a_fwd_pair: assert property (sw.highA |-> sw == 4'h9)
        else $error("bad forward");
    a_rev_pair: assert property (sw.highB |-> sw == 4'h6)
        else $error("bad reverse");
    a_uv_off: assert property ((|senseFlags[2:0]) [*4] |-> sw == 4'h0)
        else $error("drive in undervoltage");
    a_fault_low: assert property ((|senseFlags[3:0]) [*4] |-> !faultIndicator)
        else $error("fault output high");
    a_drive_diag: assert property (sw.highA && $past(sw.highA) && senseFlags == 6'h0
        |-> faultIndicator)
        else $error("fault output low in drive");
    a_ocp_off: assert property ($rose(senseFlags.overcurrent) && |sw
        |-> ##4 (sw == 4'h0 && !faultIndicator) [*8])
        else $error("overcurrent not off");
    cover property (sw == 4'h5);
    cover property (sw == 4'h1);
    cover property ($fell(faultIndicator));
endmodule : hb_checker
bind brush_dc_hbridge_control hb_checker #(.FILTER_CYC(FILTER_CYC)) chk (.mclk, .reset,
    .dirInputA, .dirInputB, .senseFlags, .bridgeSwitches, .faultIndicator);
`default_nettype wire

// File: sim/hb_ctrl_model.sv
// system controller model: direction code to input levels
// assumes the bench changes the code at most once per edge
`default_nettype none
module hb_ctrl_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] dirCode,
    output logic dirInputA,
    output logic dirInputB
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            {dirInputA, dirInputB} <= 2'h0;
        end else begin
            {dirInputA, dirInputB} <= dirCode;
        end
    end
endmodule : hb_ctrl_model
`default_nettype wire

// File: sim/brush_dc_hbridge_control_bench.sv
// bench for the h-bridge control
// assumes package and controller model compiled first
`default_nettype none
module brush_dc_hbridge_control_bench
    import hbridge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] dirCode = 2'h0;
    flags_t senseFlags = '0;
    wire logic dirInputA;
    wire logic dirInputB;
    switches_t bridgeSwitches;
    logic faultIndicator;
    int err_total = 0;
    int tests_run = 0;
    wire logic [11:0] sw = 12'(bridgeSwitches);
    always #50 mclk = ~mclk;
    hb_ctrl_model ctl (.mclk, .reset, .dirCode, .dirInputA, .dirInputB);
    brush_dc_hbridge_control #(.FILTER_CYC(2)) dut (.mclk, .reset, .dirInputA, .dirInputB,
        .senseFlags, .bridgeSwitches, .faultIndicator);
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic waitSw(logic [11:0] v);
        int n;
        for (n = 0; n < 60 && sw !== v; n++) @(negedge mclk);
        chk("switches", sw, v);
        if (n == 60) test_done();
    endtask : waitSw
    task automatic setDir(logic [1:0] c);
        @(posedge mclk);
        dirCode <= c;
    endtask : setDir
    task automatic pulse(int b, int len);
        @(posedge mclk);
        senseFlags[b] <= 1'b1;
        repeat (len) @(posedge mclk);
        senseFlags[b] <= 1'b0;
    endtask : pulse
    task automatic tModes();
        logic [11:0] exp [4] = '{12'h0, 12'h6, 12'h9, 12'h5};
        for (int c = 0; c < 4; c++) begin
            setDir(2'(c));
            waitSw(exp[c]);
        end
    endtask : tModes
    task automatic tGlitch();
        setDir(2'h2);
        waitSw(12'h9);
        chk("fault", 12'(faultIndicator), 12'h1);
        setDir(2'h0);
        setDir(2'h2);
        repeat (12) begin
            @(negedge mclk);
            chk("glitch", sw, 12'h9);
        end
    endtask : tGlitch
    task automatic tChop();
        int n;
        int tog = 0;
        logic last;
        repeat (60) @(negedge mclk);
        pulse(5, 4);
        waitSw(12'h1);
        last = faultIndicator;
        for (n = 0; n < 400 && sw === 12'h1; n++) begin
            @(negedge mclk);
            tog += int'(faultIndicator != last);
            last = faultIndicator;
        end
        chk("offtime", 12'(n), 12'(OFF_CYC));
        chk("pulses", 12'(tog >= 4), 12'h1);
        waitSw(12'h9);
        pulse(5, 20);
        repeat (30) begin
            @(negedge mclk);
            chk("blank", sw, 12'h9);
        end
    endtask : tChop
    task automatic tOcp();
        int n;
        pulse(4, 4);
        waitSw(12'h0);
        @(negedge mclk);
        chk("ocpdiag", 12'(faultIndicator), 12'h0);
        for (n = 0; n < 1600 && sw === 12'h0; n++) @(negedge mclk);
        chk("ocpoff", 12'(n >= OCP_OFF_CYC && n <= OCP_OFF_CYC + DEAD_CYC + 1), 12'h1);
        waitSw(12'h9);
    endtask : tOcp
    task automatic tSupply();
        for (int b = 0; b < 4; b++) begin
            @(posedge mclk);
            senseFlags[b] <= 1'b1;
            waitSw(12'h0);
            repeat (4) @(negedge mclk);
            chk("uvdiag", 12'(faultIndicator), 12'h0);
            @(posedge mclk);
            senseFlags[b] <= 1'b0;
            waitSw(12'h9);
        end
    endtask : tSupply
    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        tModes();
        tGlitch();
        tChop();
        tOcp();
        tSupply();
        test_done();
    end
endmodule : brush_dc_hbridge_control_bench
`default_nettype wire
